// ---- include/pwsc_map.svh ----
// register-free constant map of the pot wiper serial command decoder
`ifndef PWSC_MAP_SVH
`define PWSC_MAP_SVH

// ---------------------------------------------------------------
// frame identifier and opcodes
// ---------------------------------------------------------------
`define PWSC_DEV_ID      7'h2E
`define PWSC_OP_RD_LIVE   4'h9
`define PWSC_OP_WR_LIVE   4'hA
`define PWSC_OP_RD_STORED 4'hB
`define PWSC_OP_WR_STORED 4'hC
`define PWSC_OP_D2W      4'hD
`define PWSC_OP_W2D      4'hE
`define PWSC_OP_STEP     8'h20
`define PWSC_OP_STAT     8'h51

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define PWSC_OPC_HI      7
`define PWSC_OPC_LO      4
`define PWSC_SEL_HI      3
`define PWSC_SEL_LO      2
`define PWSC_WIPER_MAX   6'h3F
`define PWSC_WIPER_RST   6'h00
`define PWSC_STORED_RST  6'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PWSC_CLK_MHZ     125
`define PWSC_T_WR_US     10000
`define PWSC_NV_CYCLES   (`PWSC_T_WR_US * `PWSC_CLK_MHZ)

`endif

// ---- include/pwsc_pkg.sv ----
// types of the pot wiper serial command decoder
`default_nettype none
package pwsc_pkg;

  typedef logic [20:0] pwsc_busy_t;
  typedef logic [5:0]  pwsc_pos_t;

  typedef enum logic [2:0] {
    PWSC_IDLE = 3'h0,
    PWSC_ADDR = 3'h1,
    PWSC_OPC  = 3'h3,
    PWSC_DATA = 3'h2,
    PWSC_RD   = 3'h6,
    PWSC_STEP = 3'h7,
    PWSC_XFER = 3'h5,
    PWSC_WAIT = 3'h4
  } pwsc_state_e;

  typedef struct packed {
    pwsc_state_e        state;
    logic [2:0]         bit_cnt;
    logic [7:0]         shift;
    logic [7:0]         opcode;
    logic [7:0]         out_sh;
    logic               so;
    logic               so_oe;
    pwsc_pos_t          wiper;
    pwsc_pos_t [3:0]    stored;
    pwsc_busy_t         busy_cnt;
    logic               busy;
  } pwsc_core_s;

  typedef struct packed {
    logic [1:0] cs_sy;
    logic [1:0] sck_sy;
    logic [1:0] si_sy;
    logic [1:0] a_sy;
    logic       cs_d;
    logic       sck_d;
    logic       start_stb;
    logic       end_stb;
    logic       bit_stb;
    logic       bit_val;
    logic       fall_stb;
    logic       addr_lvl;
  } pwsc_rx_s;

endpackage
`default_nettype wire

// ---- include/pwsc_link_if.sv ----
// events from the serial front end to the command core
`timescale 1ns/10ps
`default_nettype none
interface pwsc_link_if;
  logic start_stb;
  logic end_stb;
  logic bit_stb;
  logic bit_val;
  logic fall_stb;
  logic addr_lvl;

  modport rx   (output start_stb, end_stb, bit_stb, bit_val, fall_stb, addr_lvl);
  modport core (input  start_stb, end_stb, bit_stb, bit_val, fall_stb, addr_lvl);
endinterface
`default_nettype wire

// ---- logic/pwsc_rx.sv ----
// serial front end: pin synchronisers and frame/clock edge events
`timescale 1ns/10ps
`default_nettype none
module pwsc_rx (
  input  wire logic  clk_sys_in,
  input  wire logic  arst_n_in,
  input  wire logic  cs_n_in,
  input  wire logic  sck_in,
  input  wire logic  si_in,
  input  wire logic  addr_in,
  pwsc_link_if.rx    lnk
);

  pwsc_pkg::pwsc_rx_s r_r;
  pwsc_pkg::pwsc_rx_s r_nxt;

  // ---------------------------------------------------------------
  // two-stage synchronisers, edges seen only on the second stage
  // ---------------------------------------------------------------
  always_comb begin
    r_nxt           = r_r;
    r_nxt.cs_sy     = {r_r.cs_sy[0], cs_n_in};
    r_nxt.sck_sy    = {r_r.sck_sy[0], sck_in};
    r_nxt.si_sy     = {r_r.si_sy[0], si_in};
    r_nxt.a_sy      = {r_r.a_sy[0], addr_in};
    r_nxt.cs_d      = r_r.cs_sy[1];
    r_nxt.sck_d     = r_r.sck_sy[1];
    r_nxt.start_stb = r_r.cs_d & ~r_r.cs_sy[1];
    r_nxt.end_stb   = ~r_r.cs_d & r_r.cs_sy[1];
    r_nxt.bit_stb   = ~r_r.cs_sy[1] & ~r_r.sck_d & r_r.sck_sy[1];
    r_nxt.fall_stb  = ~r_r.cs_sy[1] & r_r.sck_d & ~r_r.sck_sy[1];
    // si is delayed like sck, so it is sampled as of the rising edge
    r_nxt.bit_val   = r_r.si_sy[1];
    r_nxt.addr_lvl  = r_r.a_sy[1];
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_r       <= '0;
      r_r.cs_sy <= 2'h3;
      r_r.cs_d  <= 1'h1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign lnk.start_stb = r_r.start_stb;
  assign lnk.end_stb   = r_r.end_stb;
  assign lnk.bit_stb   = r_r.bit_stb;
  assign lnk.bit_val   = r_r.bit_val;
  assign lnk.fall_stb  = r_r.fall_stb;
  assign lnk.addr_lvl  = r_r.addr_lvl;

endmodule // pwsc_rx
`default_nettype wire

// ---- logic/pwsc_top.sv ----
// command core of the single pot wiper serial command decoder
`include "pwsc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pwsc_top #(
  parameter int unsigned NV_WRITE_CYCLES = `PWSC_NV_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  input  wire logic        cs_n_in,
  input  wire logic        sck_in,
  input  wire logic        si_in,
  input  wire logic        addr_select_pin_in,
  output logic             so_out,
  output logic             so_oe_out,
  output logic [5:0]       live_wiper_out,
  output logic             write_busy_out
);

  if (NV_WRITE_CYCLES < 16 || NV_WRITE_CYCLES > 32'h001FFFFF) begin : g_bad_cycles
    $error("NV_WRITE_CYCLES out of range for the busy counter");
  end

  pwsc_link_if lnk ();

  pwsc_rx u_rx (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .cs_n_in    (cs_n_in),
    .sck_in     (sck_in),
    .si_in      (si_in),
    .addr_in    (addr_select_pin_in),
    .lnk        (lnk)
  );

  // ---------------------------------------------------------------
  // opcode decode
  // ---------------------------------------------------------------
  function automatic pwsc_pkg::pwsc_state_e op_next(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[`PWSC_OPC_HI:`PWSC_OPC_LO];
    op_next = pwsc_pkg::PWSC_WAIT;
    if (op == `PWSC_OP_STEP) begin
      op_next = pwsc_pkg::PWSC_STEP;
    end else if (op == `PWSC_OP_STAT) begin
      op_next = pwsc_pkg::PWSC_RD;
    end else if (op[1:0] == 2'h0) begin
      case (hi)
        `PWSC_OP_RD_LIVE, `PWSC_OP_RD_STORED: op_next = pwsc_pkg::PWSC_RD;
        `PWSC_OP_WR_LIVE, `PWSC_OP_WR_STORED: op_next = pwsc_pkg::PWSC_DATA;
        `PWSC_OP_D2W, `PWSC_OP_W2D:           op_next = pwsc_pkg::PWSC_XFER;
        default:                         op_next = pwsc_pkg::PWSC_WAIT;
      endcase
    end
  endfunction

  pwsc_pkg::pwsc_core_s st_r;
  pwsc_pkg::pwsc_core_s st_nxt;

  logic             nv_go;
  logic             xfer_d2w;
  logic             xfer_w2d;
  logic             stat_go;
  logic             step_bit;
  logic             addr_bad;
  logic [1:0]       sel_c;
  logic [7:0]       byte_c;
  logic [1:0]       new_sel;
  pwsc_pkg::pwsc_pos_t xfer_val;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    nv_go    = 1'h0;
    xfer_d2w = 1'h0;
    xfer_w2d = 1'h0;
    stat_go  = 1'h0;
    step_bit = 1'h0;
    addr_bad = 1'h0;
    sel_c    = st_r.opcode[`PWSC_SEL_HI:`PWSC_SEL_LO];
    xfer_val = st_r.stored[sel_c];
    byte_c   = {st_r.shift[6:0], lnk.bit_val};
    new_sel  = byte_c[`PWSC_SEL_HI:`PWSC_SEL_LO];

    if (st_r.busy_cnt != '0) begin
      st_nxt.busy_cnt = st_r.busy_cnt - 21'h000001;
    end

    if (lnk.start_stb) begin
      st_nxt.state   = pwsc_pkg::PWSC_ADDR;
      st_nxt.bit_cnt = 3'h0;
      st_nxt.so      = 1'h0;
      st_nxt.so_oe   = 1'h0;
    end else if (lnk.end_stb) begin
      // transfers act only once select rises on a complete opcode
      if (st_r.state == pwsc_pkg::PWSC_XFER) begin
        if (st_r.opcode[7:4] == `PWSC_OP_D2W) begin
          xfer_d2w     = 1'h1;
          st_nxt.wiper = xfer_val;
        end else if (!st_r.busy) begin
          xfer_w2d             = 1'h1;
          nv_go                = 1'h1;
          st_nxt.stored[sel_c] = st_r.wiper;
        end
      end
      st_nxt.state = pwsc_pkg::PWSC_IDLE;
      st_nxt.so    = 1'h0;
      st_nxt.so_oe = 1'h0;
    end else begin
      // output changes on the falling clock so it is stable at the rise
      if (lnk.fall_stb && st_r.state == pwsc_pkg::PWSC_RD) begin
        st_nxt.so     = st_r.out_sh[7];
        st_nxt.out_sh = {st_r.out_sh[6:0], 1'h0};
        st_nxt.so_oe  = 1'h1;
      end
      if (lnk.bit_stb) begin
        st_nxt.shift   = byte_c;
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        case (st_r.state)
          pwsc_pkg::PWSC_ADDR: begin
            if (st_r.bit_cnt == 3'h7) begin
              if (byte_c[7:1] == `PWSC_DEV_ID && byte_c[0] == lnk.addr_lvl) begin
                st_nxt.state = pwsc_pkg::PWSC_OPC;
              end else begin
                addr_bad     = 1'h1;
                st_nxt.state = pwsc_pkg::PWSC_WAIT;
              end
            end
          end
          pwsc_pkg::PWSC_OPC: begin
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.opcode = byte_c;
              st_nxt.state  = op_next(byte_c);
              if (byte_c == `PWSC_OP_STAT) begin
                stat_go       = 1'h1;
                st_nxt.out_sh = {7'h00, st_r.busy};
              end else if (byte_c[7:4] == `PWSC_OP_RD_LIVE) begin
                st_nxt.out_sh = {2'h0, st_r.wiper};
              end else begin
                st_nxt.out_sh = {2'h0, st_r.stored[new_sel]};
              end
            end
          end
          pwsc_pkg::PWSC_DATA: begin
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.state = pwsc_pkg::PWSC_WAIT;
              if (st_r.opcode[7:4] == `PWSC_OP_WR_LIVE) begin
                st_nxt.wiper = byte_c[5:0];
              end else if (!st_r.busy) begin
                nv_go                = 1'h1;
                st_nxt.stored[sel_c] = byte_c[5:0];
              end
            end
          end
          pwsc_pkg::PWSC_STEP: begin
            step_bit = 1'h1;
            if (lnk.bit_val && st_r.wiper != `PWSC_WIPER_MAX) begin
              st_nxt.wiper = st_r.wiper + 6'h01;
            end else if (!lnk.bit_val && st_r.wiper != 6'h00) begin
              st_nxt.wiper = st_r.wiper - 6'h01;
            end
          end
          default: ;
        endcase
      end
    end

    if (nv_go) begin
      st_nxt.busy_cnt = pwsc_pkg::pwsc_busy_t'(NV_WRITE_CYCLES);
    end
    st_nxt.busy = (st_nxt.busy_cnt != '0);
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r        <= '0;
      st_r.state  <= pwsc_pkg::PWSC_IDLE;
      st_r.wiper  <= `PWSC_WIPER_RST;
      st_r.stored <= {4{`PWSC_STORED_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so_out         = st_r.so;
  assign so_oe_out      = st_r.so_oe;
  assign live_wiper_out = st_r.wiper;
  assign write_busy_out = st_r.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  chk_busy_start: assert property (nv_go |=> write_busy_out)
    else $error("write cycle did not raise busy");
  chk_busy_hold: assert property ($rose(write_busy_out) |-> write_busy_out [*8])
    else $error("busy dropped early");
  chk_xfer_wiper: assert property (xfer_d2w |=> live_wiper_out == $past(xfer_val))
    else $error("stored to wiper copy wrong");
  chk_xfer_stored: assert property (
      xfer_w2d |=> st_r.stored[$past(sel_c)] == $past(live_wiper_out) && write_busy_out)
    else $error("wiper to stored copy wrong");
  chk_step_up: assert property (
      step_bit && lnk.bit_val && live_wiper_out != 6'h3F
      |=> live_wiper_out == $past(live_wiper_out) + 6'h01)
    else $error("step up wrong");
  chk_step_down: assert property (
      step_bit && !lnk.bit_val && live_wiper_out != 6'h00
      |=> live_wiper_out == $past(live_wiper_out) - 6'h01)
    else $error("step down wrong");
  chk_status_byte: assert property (
      stat_go |=> st_r.out_sh == {7'h00, $past(write_busy_out)})
    else $error("status byte wrong");
  chk_ignore_frame: assert property (
      addr_bad |=> st_r.state == pwsc_pkg::PWSC_WAIT && !so_oe_out)
    else $error("mismatched frame not ignored");
  chk_ignore_hold: assert property (
      st_r.state == pwsc_pkg::PWSC_WAIT && !lnk.start_stb && !lnk.end_stb
      |=> st_r.state == pwsc_pkg::PWSC_WAIT && $stable(live_wiper_out))
    else $error("ignored frame acted");

  cov_nv_write: cover property (nv_go);
  cov_xfer: cover property (xfer_d2w);
  cov_status: cover property (stat_go ##[1:200] lnk.end_stb);
  cov_step: cover property (step_bit ##[1:100] step_bit);

endmodule // pwsc_top
`default_nettype wire

// ---- bench/pwsc_host.sv ----
// serial host model that frames commands and samples the returned data
`timescale 1ns/10ps
`default_nettype none
module pwsc_host (
  input  wire logic clk_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in
);
  localparam realtime HALF = 62.5ns;

  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame, msb first, clock idles low
  // ---------------------------------------------------------------
  // data is set while the clock is low and read back at its rise
  task automatic xfer(input logic tx[$], output logic rx[$]);
    rx = {};
    // launch just off a system clock edge so no pin moves on a sampling edge
    @(posedge clk_in);
    #1.25;
    cs_n_out = 1'b0;
    #HALF;
    foreach (tx[i]) begin
      si_out = tx[i];
      #HALF;
      sck_out = 1'b1;
      rx.push_back(so_in);
      #HALF;
      sck_out = 1'b0;
    end
    #HALF;
    cs_n_out = 1'b1;
    // a released data line shows the inverse, never a stale level
    si_out = ~si_out;
    // select high time well above eight system clocks
    #250;
  endtask
endmodule // pwsc_host
`default_nettype wire

// ---- bench/pot_wiper_serial_commands_bench.sv ----
// self-checking bench of the pot wiper serial command decoder
`include "pwsc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pot_wiper_serial_commands_bench;
  localparam int unsigned NV = 1024;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic        addr_pin   = 1'b1;
  wire logic   cs_n, sck, si, so, so_oe, busy;
  wire logic [5:0] wiper;
  int          bad_count  = 0;
  int          checked    = 0;
  logic [31:0] rng        = 32'hE682;
  logic        tx_q[$];
  logic        rx_q[$];
  logic [5:0]  stored_exp [4];
  logic [5:0]  v;

  pwsc_top #(.NV_WRITE_CYCLES(NV)) uut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .addr_select_pin_in(addr_pin), .so_out(so), .so_oe_out(so_oe),
    .live_wiper_out(wiper), .write_busy_out(busy));
  pwsc_host host (.clk_in(clk_sys_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so));

  always #4 clk_sys_in = ~clk_sys_in;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // steps saturate at both ends of the track
  function automatic logic [5:0] step_fn(input logic [5:0] p, input logic up);
    if (up) return (p == `PWSC_WIPER_MAX) ? p : p + 6'h01;
    return (p == 6'h00) ? p : p - 6'h01;
  endfunction

  function automatic logic [7:0] rx_byte();
    logic [7:0] b;
    for (int i = 0; i < 8; i++) b[7-i] = rx_q[16+i];
    return b;
  endfunction

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", name, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic push8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tx_q.push_back(b[i]);
  endtask

  task automatic send(input logic [6:0] id, input logic addr_bit, input logic [7:0] op,
                      input bit nd, input logic [7:0] d);
    tx_q = {};
    push8({id, addr_bit});
    push8(op);
    if (nd) push8(d);
    host.xfer(tx_q, rx_q);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      if (busy === 1'b0) return;
      @(negedge clk_sys_in);
    end
    chk1("busy wait bound", 1'b0, busy);
    end_of_test();
  endtask

  task automatic step_frame(input logic [5:0] start, input int n, input logic [31:0] bits);
    logic [5:0] e;
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_WR_LIVE, 4'h0}, 1, {2'b00, start});
    e = start;
    tx_q = {};
    push8({`PWSC_DEV_ID, 1'b1});
    push8(`PWSC_OP_STEP);
    for (int i = 0; i < n; i++) begin
      tx_q.push_back(bits[i]);
      e = step_fn(e, bits[i]);
    end
    host.xfer(tx_q, rx_q);
    chk8("wiper after steps", {2'b00, e}, {2'b00, wiper});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk8("wiper at reset", 8'h00, {2'b00, wiper});
    chk1("busy at reset", 1'b0, busy);
    for (int r = 0; r < 4; r++) begin
      rng = xs(rng);
      stored_exp[r] = rng[5:0];
      send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_WR_STORED, r[1:0], 2'b00}, 1, {2'b00, rng[5:0]});
      chk1("busy after store", 1'b1, busy);
      if (r == 0) begin
        send(`PWSC_DEV_ID, 1'b1, `PWSC_OP_STAT, 1, 8'h00);
        chk8("status while busy", 8'h01, rx_byte());
      end
      wait_idle();
    end
    send(`PWSC_DEV_ID, 1'b1, `PWSC_OP_STAT, 1, 8'h00);
    chk8("status idle", 8'h00, rx_byte());
    chk1("so_oe released", 1'b0, so_oe);
    for (int r = 0; r < 4; r++) begin
      send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_D2W, r[1:0], 2'b00}, 0, 8'h00);
      chk8("wiper after recall", {2'b00, stored_exp[r]}, {2'b00, wiper});
      send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_RD_LIVE, 4'h0}, 1, 8'h00);
      chk8("wiper read back", {2'b00, stored_exp[r]}, rx_byte());
      send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_RD_STORED, r[1:0], 2'b00}, 1, 8'h00);
      chk8("stored read back", {2'b00, stored_exp[r]}, rx_byte());
    end
    // mismatched address bit, then a wrong identifier: both must be ignored
    send(`PWSC_DEV_ID, 1'b0, {`PWSC_OP_WR_STORED, 4'h0}, 1, 8'h2A);
    chk1("busy wrong addr", 1'b0, busy);
    send(7'h2F, 1'b1, {`PWSC_OP_W2D, 4'h0}, 0, 8'h00);
    chk1("busy wrong id", 1'b0, busy);
    @(posedge clk_sys_in);
    addr_pin <= 1'b0;
    rng = xs(rng);
    send(`PWSC_DEV_ID, 1'b0, {`PWSC_OP_WR_LIVE, 4'h0}, 1, {2'b00, rng[5:0]});
    chk8("wiper direct write", {2'b00, rng[5:0]}, {2'b00, wiper});
    @(posedge clk_sys_in);
    addr_pin <= 1'b1;
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_D2W, 4'h0}, 0, 8'h00);
    chk8("store 0 untouched", {2'b00, stored_exp[0]}, {2'b00, wiper});
    step_frame(6'h01, 3, 32'h0000_0000);
    step_frame(6'h3E, 3, 32'hFFFF_FFFF);
    for (int f = 0; f < 4; f++) begin
      rng = xs(rng);
      v = rng[5:0];
      rng = xs(rng);
      step_frame(v, 20, rng);
    end
    rng = xs(rng);
    v = rng[5:0];
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_WR_LIVE, 4'h0}, 1, {2'b00, v});
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_W2D, 4'h8}, 0, 8'h00);
    chk1("busy after save", 1'b1, busy);
    wait_idle();
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_WR_LIVE, 4'h0}, 1, {2'b00, ~v});
    send(`PWSC_DEV_ID, 1'b1, {`PWSC_OP_D2W, 4'h8}, 0, 8'h00);
    chk8("saved wiper recall", {2'b00, v}, {2'b00, wiper});
    end_of_test();
  end
endmodule // pot_wiper_serial_commands_bench
`default_nettype wire
